// File: verilog/dbu_breakpoint.sv
/*
  Debug breakpoint unit: holds the breakpoint registers written by
  coprocessor moves and compares execute-stage program counter and
  load/store accesses, raising prefetch and data abort requests.
  Assumes the core holds a memory access valid for one cycle, stalls the
  following instruction until the abort answer of the next cycle, and
  ORs the fault status bit into its own fault status register.
*/
// Notes on behaviour
// R1: instruction control bit 0 arms the instruction breakpoint.
// R2: instruction control bit 1 is reserved; writes do not affect matching.
// R3: instruction compare uses address bits 31..2 only.
// R4: armed match with executing program counter gives a prefetch abort.
// R5: instruction control register is 32 bits: address plus enable.
// R6: instruction register is written via coprocessor 15 register 14, privileged only.
// R7: data address register is full 32 bits, compared on every bit.
// R8: 32-bit value register holds the store data pattern.
// R9: mask bit one includes that value bit in the store data compare.
// R10: store data breakpoint needs store address breakpoint enabled and matching.
// R11: loads break on address match only; load data is never compared.
// R12: data control has separate enables for load, store address, store data.
// R13: data breakpoint gives a data abort and fault status bit 9.
// R14: data address, value, mask written via coprocessor 15 register 14, privileged.
// R15: data control enables sit in bits 0, 1, 2; other bits read zero.
// R16: data compare per access; abort flags that very access.
module dbu_breakpoint (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // coprocessor register access
  input wire dbu_pkg::dbu_cp_req_s cp_req,
  output logic [31:0] cp_rdata,
  output logic cp_ack,
  output logic cp_undef,
  // execute stage
  input wire logic exec_valid,
  input wire logic [31:0] exec_pc,
  output logic prefetch_abort,
  // load/store unit
  input wire dbu_pkg::dbu_mem_s mem_acc,
  output logic data_abort,
  output logic [31:0] fault_status_set
);

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic [31:0] instr_breakpoint_ctrl_q, instr_breakpoint_ctrl_d;
  logic [31:0] data_breakpoint_addr_q, data_breakpoint_addr_d;
  logic [31:0] data_breakpoint_value_q, data_breakpoint_value_d;
  logic [31:0] data_breakpoint_mask_q, data_breakpoint_mask_d;
  logic [2:0] data_breakpoint_ctrl_q, data_breakpoint_ctrl_d;
  logic [31:0] cp_rdata_q, cp_rdata_d;
  logic cp_ack_q, cp_ack_d;
  logic cp_undef_q, cp_undef_d;
  logic hit_cp;
  logic allowed;

  // decode: only our coprocessor register, only from a privileged mode
  assign hit_cp = (cp_req.cp_num == dbu_pkg::CP_NUM) && (cp_req.cp_reg == dbu_pkg::CP_REG);
  assign allowed = hit_cp && cp_req.privileged; // R6 R14

  // next values of the programmable registers and of the read answer
  always_comb begin
    instr_breakpoint_ctrl_d = instr_breakpoint_ctrl_q;
    data_breakpoint_addr_d = data_breakpoint_addr_q;
    data_breakpoint_value_d = data_breakpoint_value_q;
    data_breakpoint_mask_d = data_breakpoint_mask_q;
    data_breakpoint_ctrl_d = data_breakpoint_ctrl_q;
    cp_rdata_d = 32'h0000_0000;
    cp_ack_d = allowed && (cp_req.wr || cp_req.rd);
    // unprivileged moves are refused so the core can take an undefined trap
    cp_undef_d = hit_cp && !cp_req.privileged && (cp_req.wr || cp_req.rd);
    if (allowed && cp_req.wr) begin
      unique case (cp_req.sel)
        dbu_pkg::SEL_IBRK_CTRL: begin
          // bit 1 is reserved: stored as zero so it never reaches the compare
          instr_breakpoint_ctrl_d = cp_req.wdata; // R5 R6
          instr_breakpoint_ctrl_d[dbu_pkg::IBRK_RSVD_BIT] = 1'b0; // R2
        end
        dbu_pkg::SEL_DBRK_ADDR: data_breakpoint_addr_d = cp_req.wdata; // R7 R14
        dbu_pkg::SEL_DBRK_VALUE: data_breakpoint_value_d = cp_req.wdata; // R8 R14
        dbu_pkg::SEL_DBRK_MASK: data_breakpoint_mask_d = cp_req.wdata; // R9 R14
        dbu_pkg::SEL_DBRK_CTRL: data_breakpoint_ctrl_d = cp_req.wdata[2:0]; // R12 R15
        default: ; // unmapped selector: write ignored
      endcase
    end
    if (allowed && cp_req.rd) begin
      unique case (cp_req.sel)
        dbu_pkg::SEL_IBRK_CTRL: cp_rdata_d = instr_breakpoint_ctrl_q;
        dbu_pkg::SEL_DBRK_ADDR: cp_rdata_d = data_breakpoint_addr_q;
        dbu_pkg::SEL_DBRK_VALUE: cp_rdata_d = data_breakpoint_value_q;
        dbu_pkg::SEL_DBRK_MASK: cp_rdata_d = data_breakpoint_mask_q;
        dbu_pkg::SEL_DBRK_CTRL: cp_rdata_d = {29'h0000_0000, data_breakpoint_ctrl_q}; // R15
        default: cp_rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // register stage for the programmable registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      instr_breakpoint_ctrl_q <= dbu_pkg::IBRK_CTRL_RST;
      data_breakpoint_addr_q <= dbu_pkg::DBRK_ADDR_RST;
      data_breakpoint_value_q <= dbu_pkg::DBRK_VALUE_RST;
      data_breakpoint_mask_q <= dbu_pkg::DBRK_MASK_RST;
      data_breakpoint_ctrl_q <= dbu_pkg::DBRK_CTRL_RST;
      cp_rdata_q <= 32'h0000_0000;
      cp_ack_q <= 1'b0;
      cp_undef_q <= 1'b0;
    end else begin
      instr_breakpoint_ctrl_q <= instr_breakpoint_ctrl_d;
      data_breakpoint_addr_q <= data_breakpoint_addr_d;
      data_breakpoint_value_q <= data_breakpoint_value_d;
      data_breakpoint_mask_q <= data_breakpoint_mask_d;
      data_breakpoint_ctrl_q <= data_breakpoint_ctrl_d;
      cp_rdata_q <= cp_rdata_d;
      cp_ack_q <= cp_ack_d;
      cp_undef_q <= cp_undef_d;
    end
  end

  assign cp_rdata = cp_rdata_q;
  assign cp_ack = cp_ack_q;
  assign cp_undef = cp_undef_q;

  // ----------------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------------
  logic ibrk_match;
  logic addr_match;
  logic data_match;
  logic load_hit;
  logic store_addr_hit;
  logic store_data_hit;
  logic prefetch_abort_q, prefetch_abort_d;
  logic data_abort_q, data_abort_d;

  // instruction compare ignores the two byte-offset bits
  assign ibrk_match = instr_breakpoint_ctrl_q[dbu_pkg::IBRK_EN_BIT] // R1
    && (exec_pc[31:dbu_pkg::IBRK_ADDR_LSB] == instr_breakpoint_ctrl_q[31:dbu_pkg::IBRK_ADDR_LSB]); // R3

  // full address so single byte accesses can be caught
  assign addr_match = (mem_acc.addr == data_breakpoint_addr_q); // R7

  // only mask-selected bits of the store data take part
  assign data_match = ((mem_acc.wdata ^ data_breakpoint_value_q) & data_breakpoint_mask_q) == 32'h0000_0000; // R8 R9

  // loads never look at data; the data condition needs the address condition
  assign load_hit = !mem_acc.is_store && data_breakpoint_ctrl_q[dbu_pkg::DBRK_LOAD_EN_BIT] && addr_match; // R11 R12
  assign store_addr_hit = mem_acc.is_store && data_breakpoint_ctrl_q[dbu_pkg::DBRK_STORE_EN_BIT] && addr_match;
  assign store_data_hit = store_addr_hit && data_breakpoint_ctrl_q[dbu_pkg::DBRK_DATA_EN_BIT] && data_match; // R10

  // abort answers: a store with data enabled fires only on the data match
  always_comb begin
    prefetch_abort_d = exec_valid && ibrk_match; // R4
    data_abort_d = 1'b0;
    if (mem_acc.valid) begin // R16
      if (mem_acc.is_store) begin
        data_abort_d = data_breakpoint_ctrl_q[dbu_pkg::DBRK_DATA_EN_BIT] ? store_data_hit : store_addr_hit;
      end else begin
        data_abort_d = load_hit;
      end
    end
  end

  // abort flags registered so outputs come from flip-flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prefetch_abort_q <= 1'b0;
      data_abort_q <= 1'b0;
    end else begin
      prefetch_abort_q <= prefetch_abort_d;
      data_abort_q <= data_abort_d; // R13 R16
    end
  end

  assign prefetch_abort = prefetch_abort_q;
  assign data_abort = data_abort_q;
  // fault status bit 9 tracks the data abort pulse
  assign fault_status_set = {22'h00_0000, data_abort_q, 9'h000}; // R13

endmodule // dbu_breakpoint

// File: verilog/dbu_pkg.sv
/*
  Package for the debug breakpoint unit: register selectors, field positions,
  reset values and the carriers between core pipeline and breakpoint logic.
  Assumes the core decodes coprocessor 15 register 14 moves and presents
  the sub-register selector, the write data and the privilege state.
*/
package dbu_pkg;

  // ----------------------------------------------------------------------
  // register selectors within coprocessor register 14
  // ----------------------------------------------------------------------
  localparam logic [3:0] CP_NUM = 4'hF;
  localparam logic [3:0] CP_REG = 4'hE;
  localparam logic [2:0] SEL_IBRK_CTRL = 3'h0;
  localparam logic [2:0] SEL_DBRK_ADDR = 3'h1;
  localparam logic [2:0] SEL_DBRK_VALUE = 3'h2;
  localparam logic [2:0] SEL_DBRK_MASK = 3'h3;
  localparam logic [2:0] SEL_DBRK_CTRL = 3'h4;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int IBRK_EN_BIT = 0;
  localparam int IBRK_RSVD_BIT = 1;
  localparam int IBRK_ADDR_LSB = 2;
  localparam int DBRK_LOAD_EN_BIT = 0;
  localparam int DBRK_STORE_EN_BIT = 1;
  localparam int DBRK_DATA_EN_BIT = 2;
  localparam int FSR_DBRK_BIT = 9;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] IBRK_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DBRK_ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] DBRK_VALUE_RST = 32'h0000_0000;
  localparam logic [31:0] DBRK_MASK_RST = 32'h0000_0000;
  localparam logic [2:0] DBRK_CTRL_RST = 3'h0;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] cp_num;
    logic [3:0] cp_reg;
    logic [2:0] sel;
    logic privileged;
    logic [31:0] wdata;
  } dbu_cp_req_s;

  typedef struct packed {
    logic valid;
    logic is_store;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dbu_mem_s;

endpackage : dbu_pkg

// File: testbench/dbu_breakpoint_asserts.sv
/* port checker for the breakpoint unit.
   assumes one core clock and rst_n synchronous, active low. */
module dbu_bp_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // watched ports
  input wire dbu_pkg::dbu_cp_req_s cp_req,
  input wire logic [31:0] cp_rdata,
  input wire logic cp_ack,
  input wire logic cp_undef,
  input wire logic exec_valid,
  input wire logic [31:0] exec_pc,
  input wire logic prefetch_abort,
  input wire dbu_pkg::dbu_mem_s mem_acc,
  input wire logic data_abort,
  input wire logic [31:0] fault_status_set
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // access aimed at the breakpoint registers
  logic hit;
  assign hit = (cp_req.wr | cp_req.rd) && cp_req.cp_num == dbu_pkg::CP_NUM && cp_req.cp_reg == dbu_pkg::CP_REG;
  a_priv_ack: assert property (hit && cp_req.privileged |=> cp_ack && !cp_undef)
    else $error("privileged access not acknowledged");
  a_unpriv_undef: assert property (hit && !cp_req.privileged |=> cp_undef && !cp_ack && cp_rdata == 0)
    else $error("unprivileged access not refused");
  a_idle_quiet: assert property (!hit |=> !cp_ack && !cp_undef)
    else $error("answer without access");
  a_ibrk_rsvd: assert property (cp_ack && $past(cp_req.rd && cp_req.sel == dbu_pkg::SEL_IBRK_CTRL) |-> !cp_rdata[1])
    else $error("reserved bit reads one");
  a_dctrl_rsvd: assert property (cp_ack && $past(cp_req.sel == dbu_pkg::SEL_DBRK_CTRL) |-> cp_rdata[31:3] == 0)
    else $error("data control upper bits nonzero");
  a_pabt_cause: assert property (prefetch_abort |-> $past(exec_valid))
    else $error("prefetch abort without execution");
  a_dabt_cause: assert property (data_abort |-> $past(mem_acc.valid))
    else $error("data abort without access");
  a_fsr_bit9: assert property (fault_status_set == {22'h0, data_abort, 9'h0})
    else $error("fault status mismatch");
  c_pabt: cover property (prefetch_abort);
  c_dabt: cover property (data_abort);
  c_undef: cover property (cp_undef);
endmodule // dbu_bp_chk

bind dbu_breakpoint dbu_bp_chk chk (.clk, .rst_n, .cp_req, .cp_rdata, .cp_ack, .cp_undef, .exec_valid,
  .exec_pc, .prefetch_abort, .mem_acc, .data_abort, .fault_status_set);

// File: testbench/dbu_core_model.sv
/* core pipeline model: coprocessor moves, executing pc, memory accesses.
   assumes the bench calls its tasks after reset is released. */
module dbu_core_model (
  // clock
  input wire logic clk,
  // towards the breakpoint unit
  output dbu_pkg::dbu_cp_req_s cp_req,
  output logic exec_valid,
  output logic [31:0] exec_pc,
  output dbu_pkg::dbu_mem_s mem_acc
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle pipeline at time zero
  initial begin
    cp_req = '0;
    exec_valid = 1'b0;
    exec_pc = '0;
    mem_acc = '0;
  end
  // one-cycle move; stale data is inverted so nothing leans on it
  task cp(input logic w, input logic [2:0] s, input logic [31:0] d, input logic p);
    @(posedge clk);
    #1 cp_req = '{w, !w, dbu_pkg::CP_NUM, dbu_pkg::CP_REG, s, p, d};
    @(posedge clk);
    #1 cp_req = '{1'b0, 1'b0, dbu_pkg::CP_NUM, dbu_pkg::CP_REG, s, p, ~d};
  endtask
  task ex(input logic [31:0] pc);
    @(posedge clk);
    #1 {exec_valid, exec_pc} = {1'b1, pc};
    @(posedge clk);
    #1 {exec_valid, exec_pc} = {1'b0, ~pc};
  endtask
  task mem(input logic st, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    #1 mem_acc = '{1'b1, st, a, d};
    @(posedge clk);
    #1 mem_acc = '{1'b0, ~st, ~a, ~d};
  endtask
endmodule // dbu_core_model

// File: testbench/test_dbu_breakpoint.sv
/* self-checking bench for the breakpoint unit.
   assumes the core model drives every input except clk and rst_n. */
module test_dbu_breakpoint;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  dbu_pkg::dbu_cp_req_s cp_req;
  dbu_pkg::dbu_mem_s mem_acc;
  logic exec_valid, cp_ack, cp_undef, prefetch_abort, data_abort;
  logic [31:0] exec_pc, cp_rdata, fault_status_set;
  int n_mismatch = 0;
  int checked = 0;
  localparam logic [31:0] DA = 32'h2000_0001;
  // 125 MHz core clock
  always #4 clk = ~clk;
  dbu_core_model core (.clk, .cp_req, .exec_valid, .exec_pc, .mem_acc);
  dbu_breakpoint uut (.clk, .rst_n, .cp_req, .cp_rdata, .cp_ack, .cp_undef, .exec_valid, .exec_pc,
    .prefetch_abort, .mem_acc, .data_abort, .fault_status_set);
  // -------------------------------------------------------------------
  // shared checks; answers stand one cycle, so look right after the edge
  // -------------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t ns got %h exp %h", $time, got, exp);
    end
  endtask
  task cpw(input logic [2:0] s, input logic [31:0] d);
    core.cp(1'b1, s, d, 1'b1);
    chk(cp_ack, 1);
  endtask
  task cpr(input logic [2:0] s, input logic [31:0] e);
    core.cp(1'b0, s, 32'h0, 1'b1);
    chk(cp_ack, 1);
    chk(cp_rdata, e);
  endtask
  task ex(input logic [31:0] pc, input logic e);
    core.ex(pc);
    chk(prefetch_abort, e);
  endtask
  task dm(input logic st, input logic [31:0] a, input logic [31:0] d, input logic e);
    core.mem(st, a, d);
    chk(data_abort, e);
    chk(fault_status_set, {22'h0, e, 9'h0});
  endtask
  task t_regs;
    for (int i = 0; i < 5; i++) cpr(3'(i), 32'h0);
    for (int i = 0; i < 5; i++) cpw(3'(i), 32'hFFFF_FFFF);
    cpr(3'h0, 32'hFFFF_FFFD);
    cpr(3'h1, 32'hFFFF_FFFF);
    cpr(3'h2, 32'hFFFF_FFFF);
    cpr(3'h3, 32'hFFFF_FFFF);
    cpr(3'h4, 32'h0000_0007);
    core.cp(1'b1, 3'h1, 32'h0, 1'b0);
    chk(cp_undef, 1);
    cpr(3'h1, 32'hFFFF_FFFF);
    core.cp(1'b1, 3'h0, 32'h0, 1'b0);
    chk(cp_undef, 1);
    cpr(3'h0, 32'hFFFF_FFFD);
    $display("test regs done");
  endtask
  task t_ibrk;
    cpw(3'h0, 32'h0000_1003);
    ex(32'h0000_1002, 1'b1);
    ex(32'h0000_1004, 1'b0);
    ex(32'h8000_1000, 1'b0);
    cpw(3'h0, 32'h0000_1002);
    ex(32'h0000_1000, 1'b0);
    $display("test ibrk done");
  endtask
  task t_dbrk;
    cpw(3'h1, DA);
    cpw(3'h2, 32'h0000_00A5);
    cpw(3'h3, 32'h0000_00FF);
    cpw(3'h4, 32'h0000_0001);
    dm(1'b0, DA, 32'h0, 1'b1);
    dm(1'b0, 32'h2000_0000, 32'h0, 1'b0);
    dm(1'b1, DA, 32'hA5, 1'b0);
    cpw(3'h4, 32'h0000_0002);
    dm(1'b1, DA, 32'h0, 1'b1);
    dm(1'b0, DA, 32'h0, 1'b0);
    cpw(3'h4, 32'h0000_0006);
    dm(1'b1, DA, 32'h1234_56A5, 1'b1);
    dm(1'b1, DA, 32'h0000_00A4, 1'b0);
    cpw(3'h4, 32'h0000_0004);
    dm(1'b1, DA, 32'h0000_00A5, 1'b0);
    $display("test dbrk done");
  endtask
  task close_out;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence after four reset cycles
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    t_regs;
    t_ibrk;
    t_dbrk;
    close_out;
  end
  // watchdog well past the roughly 85 cycles the tests need
  initial begin
    #20000;
    n_mismatch++;
    close_out;
  end
endmodule // test_dbu_breakpoint
